/* design/vitf_ctrl.sv */
// vectored interrupt controller with test flags, apb register slave
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module vitf_ctrl
  import vitf_pkg::*;
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // peripheral events and pins
  input  wire vitf_events_s         events,
  input  wire logic [NUM_PINS-1:0]  pin_edge_in,
  input  wire logic [PORT_W-1:0]    port4_in,
  input  wire logic                 break_trap,
  // core handshake
  output vitf_core_req_s            core_req,
  input  wire logic                 core_ack,
  input  wire logic                 core_retire,
  // test output
  output logic                      test_wake
);

  // register state
  logic [NUM_RANKS-1:0] req_flag;
  logic [NUM_RANKS-1:0] source_mask_flag;
  logic [NUM_RANKS-1:0] level_select_flag;
  logic                 global_irq_enable;
  logic                 in_service_level_flag;
  logic                 wdt_mode1;
  logic                 nmi_pend;
  logic                 brk_pend;
  logic [1:0]           test_flag;
  logic [1:0]           test_mask;
  logic [31:0]          rdata;
  vitf_core_req_s       req_q;

  logic [NUM_RANKS-1:0] next_req_flag;
  logic [NUM_RANKS-1:0] next_source_mask_flag;
  logic [NUM_RANKS-1:0] next_level_select_flag;
  logic                 next_global_irq_enable;
  logic                 next_in_service_level_flag;
  logic                 next_wdt_mode1;
  logic                 next_nmi_pend;
  logic                 next_brk_pend;
  logic [1:0]           next_test_flag;
  logic [1:0]           next_test_mask;
  logic [31:0]          next_rdata;
  vitf_core_req_s       next_req_q;

  // event decode and arbitration
  logic [NUM_PINS-1:0]  pin_edge_irq;
  logic [PORT_W-1:0]    port_fall;
  logic [NUM_RANKS-1:0] set_vec;
  logic [NUM_RANKS-1:0] eligible;
  logic [NUM_RANKS-1:0] elig_high;
  logic [NUM_RANKS-1:0] pick;
  logic [4:0]           win_rank;
  logic                 win_found;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_ok;
  logic                 accept;

  // pins idle low and the port idles high, so neither detector fires on reset release
  // rising edges on the external interrupt pins
  vitf_edge_detect #(
    .WIDTH   (NUM_PINS),
    .FALLING (1'b0)
  ) u_pin_edge (
    .mclk       (mclk),
    .rst        (rst),
    .pin        (pin_edge_in),
    .edge_pulse (pin_edge_irq)
  );

  // falling edges on port 4 feed the key-return test flag
  vitf_edge_detect #(
    .WIDTH   (PORT_W),
    .FALLING (1'b1)
  ) u_port_fall (
    .mclk       (mclk),
    .rst        (rst),
    .pin        (port4_in),
    .edge_pulse (port_fall)
  );

  // apb decode; slave never waits, unmapped offsets answer with an error
  assign pready = 1'b1;
  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & ~penable & ~pwrite;
  always_comb
  begin
    case (paddr)
      OFS_REQ, OFS_MASK, OFS_LEVEL, OFS_CTRL, OFS_TEST, OFS_STATUS:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // map each source onto its rank
  always_comb
  begin
    set_vec = '0;
    set_vec[RANK_WDT]    = events.watchdog_overflow_irq & ~wdt_mode1;
    set_vec[RANK_PIN0 +: NUM_PINS] = pin_edge_irq;
    set_vec[RANK_SER0]   = events.serial0_done_irq;
    set_vec[RANK_SER1]   = events.serial1_done_irq;
    set_vec[RANK_RXERR]  = events.async_rx_error_irq;
    set_vec[RANK_RXDONE] = events.async_rx_done_irq
                         | events.serial2_threewire_done_irq;
    set_vec[RANK_TXDONE] = events.async_tx_done_irq;
    set_vec[RANK_WATCH]  = events.watch_interval_irq;
    set_vec[RANK_TMR_A]  = events.wide_timer_match_a_irq;
    set_vec[RANK_TMR_B]  = events.wide_timer_match_b_irq;
    set_vec[RANK_BTMR1]  = events.byte_timer1_match_irq;
    set_vec[RANK_BTMR2]  = events.byte_timer2_match_irq;
    set_vec[RANK_ADC]    = events.conversion_done_irq;
  end

  // while a high-level service runs only high-level sources may nest
  always_comb
  begin
    eligible = req_flag & ~source_mask_flag & {NUM_RANKS{global_irq_enable}};
    if (in_service_level_flag)
      eligible = eligible & ~level_select_flag;
    elig_high = eligible & ~level_select_flag;
    pick      = (|elig_high) ? elig_high : eligible;
  end

  // fixed order: scan downward so the lowest rank is written last and wins
  // a linear scan over nineteen ranks is cheap enough to settle within one cycle
  always_comb
  begin
    win_rank  = '0;
    win_found = 1'b0;
    for (int r = NUM_RANKS - 1; r >= 0; r--)
    begin
      if (pick[r])
      begin
        win_rank  = 5'(r);
        win_found = 1'b1;
      end
    end
  end

  // an ack against an empty request does nothing, so a stray pulse cannot clear a flag
  assign accept = core_ack & req_q.req;

  // request to the core: nmi before break before maskable
  // nmi and break leave the rank field zero; only a maskable winner fills it
  always_comb
  begin
    next_req_q = '0;
    if (accept)
      next_req_q.req = 1'b0;                 // drop one cycle so the cleared flag is seen
    else if (nmi_pend)
    begin
      next_req_q.req    = 1'b1;
      next_req_q.kind   = VITF_KIND_NMI;
      next_req_q.vector = VEC_NMI;
    end
    else if (brk_pend)
    begin
      next_req_q.req    = 1'b1;
      next_req_q.kind   = VITF_KIND_BREAK;
      next_req_q.vector = VEC_BRK;
    end
    else if (win_found)
    begin
      next_req_q.req    = 1'b1;
      next_req_q.kind   = VITF_KIND_MASKABLE;
      next_req_q.rank   = win_rank;
      next_req_q.vector = VEC_NMI + {10'h000, win_rank, 1'b0};
    end
  end

  // pending non-maskable and software requests, set wins over acceptance
  always_comb
  begin
    next_nmi_pend = nmi_pend;
    next_brk_pend = brk_pend;
    if (accept && req_q.kind == VITF_KIND_NMI)
      next_nmi_pend = 1'b0;
    if (accept && req_q.kind == VITF_KIND_BREAK)
      next_brk_pend = 1'b0;
    if (events.watchdog_overflow_irq && wdt_mode1)
      next_nmi_pend = 1'b1;
    if (break_trap)
      next_brk_pend = 1'b1;
  end

  // request flags: software writes one to clear, acceptance clears, events set last
  always_comb
  begin
    next_req_flag = req_flag;
    if (wr_en && paddr == OFS_REQ)
      next_req_flag = next_req_flag & ~pwdata[NUM_RANKS-1:0];
    if (accept && req_q.kind == VITF_KIND_MASKABLE)
      next_req_flag[req_q.rank] = 1'b0;
    // an event in the clearing cycle must not be lost, so the set comes last
    next_req_flag = next_req_flag | set_vec;
  end

  // mask, level, control; a maskable acceptance disables further maskable service
  always_comb
  begin
    next_source_mask_flag      = source_mask_flag;
    next_level_select_flag     = level_select_flag;
    next_global_irq_enable     = global_irq_enable;
    next_in_service_level_flag = in_service_level_flag;
    next_wdt_mode1             = wdt_mode1;
    next_test_mask             = test_mask;
    if (wr_en && paddr == OFS_MASK)
      next_source_mask_flag = pwdata[NUM_RANKS-1:0];
    if (wr_en && paddr == OFS_LEVEL)
      next_level_select_flag = pwdata[NUM_RANKS-1:0];
    if (wr_en && paddr == OFS_CTRL)
    begin
      next_global_irq_enable     = pwdata[CTRL_IE];
      next_in_service_level_flag = pwdata[CTRL_ISP];
      next_wdt_mode1             = pwdata[CTRL_WDM1];
    end
    if (wr_en && paddr == OFS_TEST)
      next_test_mask = {pwdata[TEST_MSK_KEY], pwdata[TEST_MSK_WATCH]};
    // retire and a new high-level accept in one cycle: the new service keeps the flag set
    if (core_retire)
      next_in_service_level_flag = 1'b0;
    if (accept && req_q.kind == VITF_KIND_MASKABLE)
    begin
      next_global_irq_enable = 1'b0;
      if (!level_select_flag[req_q.rank])
        next_in_service_level_flag = 1'b1;
    end
  end

  // test flags: write one to clear, a new edge in the same cycle wins
  always_comb
  begin
    next_test_flag = test_flag;
    if (wr_en && paddr == OFS_TEST)
      next_test_flag = test_flag & ~{pwdata[TEST_KEY], pwdata[TEST_WATCH]};
    if (events.watch_overflow_test)
      next_test_flag[TEST_WATCH] = 1'b1;
    if (|port_fall)
      next_test_flag[TEST_KEY] = 1'b1;
  end

  // read mux, latched in the setup cycle so prdata comes from a flop
  // reads have no side effects, so polling a flag never loses it
  always_comb
  begin
    next_rdata = rdata;
    if (rd_en)
    begin
      next_rdata = '0;
      case (paddr)
        OFS_REQ:    next_rdata[NUM_RANKS-1:0] = req_flag;
        OFS_MASK:   next_rdata[NUM_RANKS-1:0] = source_mask_flag;
        OFS_LEVEL:  next_rdata[NUM_RANKS-1:0] = level_select_flag;
        OFS_CTRL:
        begin
          next_rdata[CTRL_IE]   = global_irq_enable;
          next_rdata[CTRL_ISP]  = in_service_level_flag;
          next_rdata[CTRL_WDM1] = wdt_mode1;
        end
        OFS_TEST:
        begin
          next_rdata[TEST_WATCH]     = test_flag[TEST_WATCH];
          next_rdata[TEST_KEY]       = test_flag[TEST_KEY];
          next_rdata[TEST_MSK_WATCH] = test_mask[0];
          next_rdata[TEST_MSK_KEY]   = test_mask[1];
        end
        OFS_STATUS:
        begin
          // vector, rank and pending state of the request now shown to the core
          next_rdata = {req_q.vector,
                        3'b000,
                        req_q.rank,
                        3'b000,
                        nmi_pend,
                        brk_pend,
                        req_q.kind,
                        req_q.req};
        end
        default:    next_rdata = '0;
      endcase
    end
  end

  // test flags only reach the wake output when unmasked; no vector results
  assign test_wake = |(test_flag & ~test_mask);
  assign prdata    = rdata;
  assign core_req  = req_q;

  // all state registers
  // one bank keeps every reset value in one place
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      req_flag              <= '0;
      source_mask_flag      <= RST_MASK;
      level_select_flag     <= RST_LEVEL;
      global_irq_enable     <= 1'b0;
      in_service_level_flag <= 1'b0;
      wdt_mode1             <= 1'b0;
      nmi_pend              <= 1'b0;
      brk_pend              <= 1'b0;
      test_flag             <= '0;
      test_mask             <= RST_TMSK;
      rdata                 <= '0;
      req_q                 <= '0;
    end
    else
    begin
      req_flag              <= next_req_flag;
      source_mask_flag      <= next_source_mask_flag;
      level_select_flag     <= next_level_select_flag;
      global_irq_enable     <= next_global_irq_enable;
      in_service_level_flag <= next_in_service_level_flag;
      wdt_mode1             <= next_wdt_mode1;
      nmi_pend              <= next_nmi_pend;
      brk_pend              <= next_brk_pend;
      test_flag             <= next_test_flag;
      test_mask             <= next_test_mask;
      rdata                 <= next_rdata;
      req_q                 <= next_req_q;
    end
  end

endmodule : vitf_ctrl
`default_nettype wire

/* design/vitf_edge_detect.sv */
// per-bit edge detector for pin inputs
`timescale 1ns/1ps
`default_nettype none
module vitf_edge_detect #(
  parameter int WIDTH   = 8,
  parameter bit FALLING = 1'b0
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // pins and edge pulses
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] edge_pulse
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  // previous sample; reset level chosen so no edge fires right after reset
  always_comb
  begin
    next_prev = pin;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prev <= FALLING ? {WIDTH{1'b0}} : {WIDTH{1'b1}};
    else
      prev <= next_prev;
  end

  // one comparator per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign edge_pulse[i] = FALLING ? (prev[i] & ~pin[i]) : (~prev[i] & pin[i]);
    end
  endgenerate

endmodule : vitf_edge_detect
`default_nettype wire

/* inc/vitf_pkg.sv */
// constants, register map and carrier types for the vectored interrupt and test flag block
package vitf_pkg;

  localparam int NUM_RANKS = 19;
  localparam int NUM_PINS  = 7;
  localparam int PORT_W    = 8;
  localparam int ADDR_W    = 8;

  // ranks of the maskable sources, 0 is served first
  localparam int RANK_WDT     = 0;
  localparam int RANK_PIN0    = 1;
  localparam int RANK_SER0    = 8;
  localparam int RANK_SER1    = 9;
  localparam int RANK_RXERR   = 10;
  localparam int RANK_RXDONE  = 11;
  localparam int RANK_TXDONE  = 12;
  localparam int RANK_WATCH   = 13;
  localparam int RANK_TMR_A   = 14;
  localparam int RANK_TMR_B   = 15;
  localparam int RANK_BTMR1   = 16;
  localparam int RANK_BTMR2   = 17;
  localparam int RANK_ADC     = 18;

  // vector table addresses; maskable vector is the nmi entry plus twice the rank
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_BRK = 16'h003E;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_REQ    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LEVEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TEST   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

  // control register fields
  localparam int CTRL_IE   = 0;
  localparam int CTRL_ISP  = 1;
  localparam int CTRL_WDM1 = 2;

  // test register fields: flags low, masks above
  localparam int TEST_WATCH    = 0;
  localparam int TEST_KEY      = 1;
  localparam int TEST_MSK_WATCH = 2;
  localparam int TEST_MSK_KEY  = 3;

  // reset values
  localparam logic [NUM_RANKS-1:0] RST_MASK  = 19'h7_FFFF;
  localparam logic [NUM_RANKS-1:0] RST_LEVEL = 19'h7_FFFF;
  localparam logic [1:0]           RST_TMSK  = 2'h3;

  // kind of request handed to the core
  typedef enum logic [1:0] {
    VITF_KIND_MASKABLE,
    VITF_KIND_NMI,
    VITF_KIND_BREAK
  } vitf_kind_e;

  // request presented to the core
  typedef struct packed {
    logic        req;
    vitf_kind_e  kind;
    logic [4:0]  rank;
    logic [15:0] vector;
  } vitf_core_req_s;

  // one-cycle event pulses from the internal peripherals
  typedef struct packed {
    logic watchdog_overflow_irq;
    logic serial0_done_irq;
    logic serial1_done_irq;
    logic async_rx_error_irq;
    logic async_rx_done_irq;
    logic serial2_threewire_done_irq;
    logic async_tx_done_irq;
    logic watch_interval_irq;
    logic wide_timer_match_a_irq;
    logic wide_timer_match_b_irq;
    logic byte_timer1_match_irq;
    logic byte_timer2_match_irq;
    logic conversion_done_irq;
    logic watch_overflow_test;
  } vitf_events_s;

endpackage : vitf_pkg

/* testbench/vitf_core_model.sv */
// processor core model: accepts requests promptly or after a stall
`timescale 1ns/1ps
`default_nettype none
module vitf_core_model
  import vitf_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           rst,
  // request side
  input  wire vitf_core_req_s core_req,
  input  wire logic           slow,
  // acceptance
  output logic                core_ack
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic       next_ack;
  // slow mode holds the request three cycles so that it must stand
  always_comb
  begin
    next_ack = 1'b0;
    next_cnt = 2'h0;
    if (core_req.req && !core_ack)
    begin
      if (!slow || cnt == 2'h3)
        next_ack = 1'b1;
      else
        next_cnt = cnt + 2'h1;
    end
  end
  // ack is a single-cycle pulse, never two in a row
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt      <= 2'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      core_ack <= next_ack;
    end
  end
endmodule : vitf_core_model
`default_nettype wire

/* testbench/vitf_ctrl_bench.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vitf_ctrl_bench
  import vitf_pkg::*;
;
  typedef struct {int src; int rank; logic [15:0] vec;} vitf_row_s;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, break_trap, core_retire, core_ack, slow, test_wake, e, ok;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata, prdata, q;
  vitf_events_s        events;
  logic [NUM_PINS-1:0] pin_edge_in;
  logic [PORT_W-1:0]   port4_in;
  vitf_core_req_s      core_req;
  int                  errors, comparisons, i;
  // source index, expected rank and vector
  vitf_row_s rows [20] = '{'{0,0,16'h0004},'{1,1,16'h0006},'{2,2,16'h0008},'{3,3,16'h000A},'{4,4,16'h000C},
    '{5,5,16'h000E},'{6,6,16'h0010},'{7,7,16'h0012},'{8,8,16'h0014},'{9,9,16'h0016},'{10,10,16'h0018},
    '{11,11,16'h001A},'{12,11,16'h001A},'{13,12,16'h001C},'{14,13,16'h001E},'{15,14,16'h0020},
    '{16,15,16'h0022},'{17,16,16'h0024},'{18,17,16'h0026},'{19,18,16'h0028}};
  vitf_ctrl vitf_ctrl_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .pin_edge_in(pin_edge_in), .port4_in(port4_in), .break_trap(break_trap), .core_req(core_req),
    .core_ack(core_ack), .core_retire(core_retire), .test_wake(test_wake));
  vitf_core_model vitf_core_model_inst (.mclk(mclk), .rst(rst), .core_req(core_req), .slow(slow),
    .core_ack(core_ack));
  always #25 mclk = ~mclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, released only after pready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq, output logic re);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, exp);
  endtask : rd
  // bits 0..19 maskable sources, bit 20 watch test input
  task pulse(input logic [20:0] s);
    vitf_events_s ev;
    int k;
    ev = '0;
    ev[13] = s[0];
    for (k = 8; k <= 20; k++) ev[20-k] = s[k];
    @(posedge mclk);
    events <= ev; pin_edge_in <= s[7:1];
    @(posedge mclk);
    events <= '0; pin_edge_in <= '0;
  endtask : pulse
  task wait_req(output logic found);
    int n;
    found = 1'b0;
    for (n = 0; n < 12 && !found; n++)
    begin
      @(negedge mclk);
      found = (core_req.req === 1'b1);
    end
  endtask : wait_req
  task wait_ack;
    int n;
    for (n = 0; n < 12 && core_ack !== 1'b1; n++) @(negedge mclk);
    @(posedge mclk);
  endtask : wait_ack
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done
  initial
  begin
    #150000;
    errors++;
    test_done();
  end
  initial
  begin
    mclk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    events = '0; pin_edge_in = '0; port4_in = 8'hFF; break_trap = 1'b0; core_retire = 1'b0; slow = 1'b0;
    errors = 0; comparisons = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_REQ, 32'h0000_0000);
    rd(OFS_MASK, 32'h0007_FFFF);
    rd(OFS_LEVEL, 32'h0007_FFFF);
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_TEST, 32'h0000_000C);
    rd(8'h18, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    chk(32'(pready), 32'h0000_0001);
    wr(OFS_MASK, 32'h0000_0000);
    for (i = 0; i < 20; i++)
    begin
      slow <= i[0];
      wr(OFS_CTRL, 32'h0000_0001);
      pulse(21'(1) << rows[i].src);
      wait_req(ok);
      chk(32'(ok), 32'h0000_0001);
      chk(32'(core_req.rank), 32'(rows[i].rank));
      chk(32'(core_req.vector), 32'(rows[i].vec));
      wait_ack();
      rd(OFS_REQ, 32'h0000_0000);
    end
    // high level beats default order; in-service holds off low level
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_LEVEL, 32'h0003_FFFF);
    pulse(21'h08_0120);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_req(ok);
    chk(32'(core_req.rank), 32'h0000_0012);
    wait_ack();
    rd(OFS_CTRL, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0003);
    wait_req(ok);
    chk(32'(ok), 32'h0000_0000);
    @(posedge mclk);
    core_retire <= 1'b1;
    @(posedge mclk);
    core_retire <= 1'b0;
    wait_req(ok);
    chk(32'(core_req.rank), 32'h0000_0005);
    wait_ack();
    wr(OFS_CTRL, 32'h0000_0001);
    wait_req(ok);
    chk(32'(core_req.rank), 32'h0000_0008);
    wait_ack();
    // a masked source keeps its flag but is not presented
    wr(OFS_MASK, 32'h0000_0100);
    wr(OFS_CTRL, 32'h0000_0001);
    pulse(21'h00_0100);
    wait_req(ok);
    chk(32'(ok), 32'h0000_0000);
    rd(OFS_REQ, 32'h0000_0100);
    wr(OFS_MASK, 32'h0000_0000);
    wait_req(ok);
    chk(32'(core_req.rank), 32'h0000_0008);
    wait_ack();
    // watchdog in mode 1 is non-maskable, with enable off and a slow core
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(21'h00_0001);
    wait_req(ok);
    chk(32'(core_req.kind), 32'(VITF_KIND_NMI));
    chk(32'(core_req.vector), 32'h0000_0004);
    rd(OFS_STATUS, 32'h0004_0013);
    wait_ack();
    rd(OFS_REQ, 32'h0000_0000);
    break_trap <= 1'b1;
    @(posedge mclk);
    break_trap <= 1'b0;
    wait_req(ok);
    chk(32'(core_req.kind), 32'(VITF_KIND_BREAK));
    chk(32'(core_req.vector), 32'h0000_003E);
    wait_ack();
    // test inputs set flags, gated by their masks
    port4_in <= 8'hEF;
    @(posedge mclk);
    port4_in <= 8'hFF;
    rd(OFS_TEST, 32'h0000_000E);
    chk(32'(test_wake), 32'h0000_0000);
    wr(OFS_TEST, 32'h0000_0004);
    @(negedge mclk);
    chk(32'(test_wake), 32'h0000_0001);
    pulse(21'h10_0000);
    rd(OFS_TEST, 32'h0000_0007);
    chk(32'(core_req.req), 32'h0000_0000);
    wr(OFS_TEST, 32'h0000_0003);
    rd(OFS_TEST, 32'h0000_0000);
    chk(32'(test_wake), 32'h0000_0000);
    // software clears a flag by writing one; a mid-run reset drops all state
    pulse(21'h00_0100);
    rd(OFS_REQ, 32'h0000_0100);
    wr(OFS_REQ, 32'h0000_0100);
    rd(OFS_REQ, 32'h0000_0000);
    pulse(21'h00_0100);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_REQ, 32'h0000_0000);
    rd(OFS_CTRL, 32'h0000_0000);
    chk(32'(core_req.req), 32'h0000_0000);
    test_done();
  end
endmodule : vitf_ctrl_bench
bind vitf_ctrl vitf_ctrl_sva vitf_ctrl_sva_inst (.mclk(mclk), .rst(rst), .break_trap(break_trap),
  .core_req(core_req), .core_ack(core_ack));
`default_nettype wire

/* testbench/vitf_ctrl_sva.sv */
// assertions on the controller core-side ports
`timescale 1ns/1ps
`default_nettype none
module vitf_ctrl_sva
  import vitf_pkg::*;
(
  // clock and reset
  input wire logic           mclk,
  input wire logic           rst,
  // core side
  input wire logic           break_trap,
  input wire vitf_core_req_s core_req,
  input wire logic           core_ack
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // maskable entries sit two bytes per rank above the first entry
  property p_vec_mask;
    core_req.req && core_req.kind == VITF_KIND_MASKABLE |->
      core_req.vector == 16'h0004 + {10'h000, core_req.rank, 1'b0};
  endproperty
  a_vec_mask: assert property (p_vec_mask)
    else $error("maskable vector off its rank");
  property p_rank_range;
    core_req.req && core_req.kind == VITF_KIND_MASKABLE |-> core_req.rank <= 5'h12;
  endproperty
  a_rank_range: assert property (p_rank_range)
    else $error("rank beyond lowest default rank");
  property p_vec_nmi;
    core_req.req && core_req.kind == VITF_KIND_NMI |-> core_req.vector == 16'h0004;
  endproperty
  a_vec_nmi: assert property (p_vec_nmi)
    else $error("nmi vector wrong");
  property p_vec_brk;
    core_req.req && core_req.kind == VITF_KIND_BREAK |-> core_req.vector == 16'h003E;
  endproperty
  a_vec_brk: assert property (p_vec_brk)
    else $error("break vector wrong");
  property p_kind_legal;
    core_req.req |-> core_req.kind != 2'h3;
  endproperty
  a_kind_legal: assert property (p_kind_legal)
    else $error("unknown request kind");
  // an accepted request must leave the bus for a cycle
  property p_ack_drop;
    core_req.req && core_ack |=> !core_req.req;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("request stayed after accept");
  property p_brk_rise;
    (break_trap && !core_req.req) ##1 !core_ack |=> core_req.req;
  endproperty
  a_brk_rise: assert property (p_brk_rise)
    else $error("break trap not presented");
  // nmi cannot be dropped or overtaken until taken
  property p_nmi_stand;
    core_req.req && core_req.kind == VITF_KIND_NMI && !core_ack |=>
      core_req.req && core_req.kind == VITF_KIND_NMI;
  endproperty
  a_nmi_stand: assert property (p_nmi_stand)
    else $error("nmi request dropped");
endmodule : vitf_ctrl_sva
`default_nettype wire
